// >>> logic/att_average.sv
// one channel's exponential data average with forced reload
`default_nettype none
module att_average
  import att_pkg::*;
#(
  parameter int DATA_W = ATT_DATA_W,
  parameter int FRAC_W = ATT_FRAC_W
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic conv_strobe,
  input wire logic force_load,
  input wire logic [DATA_W-1:0] conv_data,
  input wire logic [3:0] average_settle_exp,
  output logic [DATA_W-1:0] average
);

  initial begin
    if (FRAC_W < 16) $error("att_average: FRAC_W too small for 2**16 time constant");
  end

  localparam int ACC_W = DATA_W + FRAC_W;

  logic [ACC_W-1:0] acc;
  logic signed [ACC_W:0] diff;
  logic signed [ACC_W:0] step;
  logic [4:0] tc_exp;

  always_comb begin
    tc_exp = {1'b0, average_settle_exp} + 5'h01;
    diff = $signed({1'b0, conv_data, {FRAC_W{1'b0}}}) - $signed({1'b0, acc});
    // arithmetic shift gives the 1 - e^(-n/tc) step response
    step = diff >>> tc_exp;
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      acc <= '0;
    end else if (conv_strobe) begin
      if (force_load) begin
        acc <= {conv_data, {FRAC_W{1'b0}}};
      end else begin
        acc <= acc + step[ACC_W-1:0];
      end
    end
  end

  assign average = acc[ACC_W-1:FRAC_W];

endmodule : att_average
`default_nettype wire

// >>> logic/att_pkg.sv
// package: register map, field layout and encodings of the adaptive threshold tracker
`default_nettype none
package att_pkg;

  // =====================================================================
  // register offsets
  localparam logic [7:0] ATT_OFS_CH1_TIMEOUT = 8'h0A;
  localparam logic [7:0] ATT_OFS_CH1_SETUP = 8'h0B;
  localparam logic [7:0] ATT_OFS_CH2_TIMEOUT = 8'h0D;
  localparam logic [7:0] ATT_OFS_CH2_SETUP = 8'h0E;

  // =====================================================================
  // reset values
  localparam logic [7:0] ATT_TIMEOUT_RESET = 8'h86;
  localparam logic [7:0] ATT_SETUP_RESET = 8'h0B;

  // =====================================================================
  // timeout register fields
  localparam int ATT_APR_MSB = 7;
  localparam int ATT_APR_LSB = 4;
  localparam int ATT_REC_MSB = 3;
  localparam int ATT_REC_LSB = 0;

  // =====================================================================
  // setup register fields
  localparam int ATT_RANGE_MSB = 7;
  localparam int ATT_RANGE_LSB = 6;
  localparam int ATT_RSVD_BIT = 5;
  localparam int ATT_HYST_BIT = 4;
  localparam int ATT_SETTLE_MSB = 3;
  localparam int ATT_SETTLE_LSB = 0;

  // =====================================================================
  // data layout: 12-bit result sits in the top of a 16-bit word
  localparam int ATT_DATA_W = 16;
  localparam int ATT_SENS_SHIFT = 4;
  localparam int ATT_HYST_SHIFT = 2;
  localparam int ATT_FRAC_W = 16;
  localparam int ATT_CNT_W = 16;

  // =====================================================================
  // comparator modes
  typedef enum logic [1:0] {
    ATT_MODE_NEGATIVE = 2'b00,
    ATT_MODE_POSITIVE = 2'b01,
    ATT_MODE_IN_WINDOW = 2'b10,
    ATT_MODE_OUT_WINDOW = 2'b11
  } att_cmp_mode_e;

  // counter side tracking
  typedef enum logic [1:0] {
    ATT_SIDE_INSIDE = 2'b00,
    ATT_SIDE_APPROACH = 2'b01,
    ATT_SIDE_RECEDE = 2'b10
  } att_side_e;

endpackage : att_pkg
`default_nettype wire

// >>> logic/att_timeout_ctr.sv
// one channel's approaching and receding timeout counter
`default_nettype none
module att_timeout_ctr
  import att_pkg::*;
#(
  parameter int CNT_W = ATT_CNT_W
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic conv_strobe,
  input wire logic timeout_enable,
  input wire logic side_approach,
  input wire logic side_recede,
  input wire logic [3:0] approach_limit_exp,
  input wire logic [3:0] recede_limit_exp,
  output logic force_load
);

  initial begin
    if (CNT_W < 16) $error("att_timeout_ctr: CNT_W must hold 2**15");
  end

  att_side_e side;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic [CNT_W:0] limit;
  att_side_e cur_side;

  always_comb begin
    if (side_approach) begin
      cur_side = ATT_SIDE_APPROACH;
    end else if (side_recede) begin
      cur_side = ATT_SIDE_RECEDE;
    end else begin
      cur_side = ATT_SIDE_INSIDE;
    end
    // a change of side restarts the count
    next_count = (cur_side == side) ? count + 1'b1 : {{(CNT_W-1){1'b0}}, 1'b1};
    limit = '0;
    if (cur_side == ATT_SIDE_APPROACH) begin
      limit[approach_limit_exp] = 1'b1;
    end else begin
      limit[recede_limit_exp] = 1'b1;
    end
    force_load = conv_strobe && timeout_enable && (cur_side != ATT_SIDE_INSIDE) &&
      ({1'b0, next_count} >= limit);
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      side <= ATT_SIDE_INSIDE;
      count <= '0;
    end else if (conv_strobe) begin
      if (!timeout_enable || cur_side == ATT_SIDE_INSIDE || force_load) begin
        side <= ATT_SIDE_INSIDE;
        count <= '0;
      end else begin
        side <= cur_side;
        count <= next_count;
      end
    end
  end

endmodule : att_timeout_ctr
`default_nettype wire

// >>> logic/att_tracker.sv
// adaptive threshold tracker for two capacitance channels
`default_nettype none
module att_tracker
  import att_pkg::*;
#(
  parameter int DATA_W = ATT_DATA_W
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_wr_data,
  input wire logic reg_rd_en,
  output logic [7:0] reg_rd_data,
  input wire logic threshold_fixed,
  input wire logic [1:0] comparator_mode_sel,
  input wire logic [7:0] ch1_sensitivity,
  input wire logic [7:0] ch2_sensitivity,
  input wire logic [DATA_W-1:0] ch1_fixed_threshold,
  input wire logic [DATA_W-1:0] ch2_fixed_threshold,
  input wire logic conv_valid,
  input wire logic conv_channel,
  input wire logic [DATA_W-1:0] conv_data,
  output logic [DATA_W-1:0] ch1_average,
  output logic [DATA_W-1:0] ch2_average,
  output logic [DATA_W:0] ch1_upper_threshold,
  output logic [DATA_W:0] ch2_upper_threshold,
  output logic [DATA_W-1:0] ch1_lower_threshold,
  output logic [DATA_W-1:0] ch2_lower_threshold,
  output logic ch1_detect,
  output logic ch2_detect,
  output logic [4:0] ch1_range_quarter_pf,
  output logic [4:0] ch2_range_quarter_pf,
  output logic [3:0] ch1_offset_dac_step,
  output logic [3:0] ch2_offset_dac_step
);

  initial begin
    if (DATA_W != ATT_DATA_W) $error("att_tracker: DATA_W must be 16");
  end

  // =====================================================================
  // helpers
  function automatic logic [3:0] offset_dac_step(input logic [1:0] range_sel);
    case (range_sel)
      2'b00: offset_dac_step = 4'h4;
      2'b01: offset_dac_step = 4'h1;
      2'b10: offset_dac_step = 4'h2;
      default: offset_dac_step = 4'h8;
    endcase
  endfunction : offset_dac_step

  // range in quarter picofarads: 2, 0.5, 1, 4 pF
  function automatic logic [4:0] input_range_qpf(input logic [1:0] range_sel);
    case (range_sel)
      2'b00: input_range_qpf = 5'h08;
      2'b01: input_range_qpf = 5'h02;
      2'b10: input_range_qpf = 5'h04;
      default: input_range_qpf = 5'h10;
    endcase
  endfunction : input_range_qpf

  // clamp at zero so a small average cannot wrap the lower threshold
  function automatic logic [DATA_W-1:0] sub_floor(
    input logic [DATA_W-1:0] a,
    input logic [DATA_W-1:0] b
  );
    sub_floor = (a > b) ? a - b : '0;
  endfunction : sub_floor

  // =====================================================================
  // registers
  logic [7:0] ch1_timeout_cfg;
  logic [7:0] ch1_threshold_setup;
  logic [7:0] ch2_timeout_cfg;
  logic [7:0] ch2_threshold_setup;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      ch1_timeout_cfg <= ATT_TIMEOUT_RESET;
      ch2_timeout_cfg <= ATT_TIMEOUT_RESET;
      ch1_threshold_setup <= ATT_SETUP_RESET;
      ch2_threshold_setup <= ATT_SETUP_RESET;
    end else if (reg_wr_en) begin
      if (reg_addr == ATT_OFS_CH1_TIMEOUT) begin
        ch1_timeout_cfg <= reg_wr_data;
      end else if (reg_addr == ATT_OFS_CH1_SETUP) begin
        // bit 5 is stored as written; nonzero values leave operation unspecified
        ch1_threshold_setup <= reg_wr_data;
      end else if (reg_addr == ATT_OFS_CH2_TIMEOUT) begin
        ch2_timeout_cfg <= reg_wr_data;
      end else if (reg_addr == ATT_OFS_CH2_SETUP) begin
        ch2_threshold_setup <= reg_wr_data;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      reg_rd_data <= 8'h00;
    end else if (reg_rd_en) begin
      if (reg_addr == ATT_OFS_CH1_TIMEOUT) begin
        reg_rd_data <= ch1_timeout_cfg;
      end else if (reg_addr == ATT_OFS_CH1_SETUP) begin
        reg_rd_data <= ch1_threshold_setup;
      end else if (reg_addr == ATT_OFS_CH2_TIMEOUT) begin
        reg_rd_data <= ch2_timeout_cfg;
      end else if (reg_addr == ATT_OFS_CH2_SETUP) begin
        reg_rd_data <= ch2_threshold_setup;
      end else begin
        reg_rd_data <= 8'h00;
      end
    end
  end

  // =====================================================================
  // range decode
  logic [1:0] ch1_range_sel;
  logic [1:0] ch2_range_sel;

  assign ch1_range_sel = ch1_threshold_setup[ATT_RANGE_MSB:ATT_RANGE_LSB];
  assign ch2_range_sel = ch2_threshold_setup[ATT_RANGE_MSB:ATT_RANGE_LSB];

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      ch1_range_quarter_pf <= input_range_qpf(2'b00);
      ch2_range_quarter_pf <= input_range_qpf(2'b00);
      ch1_offset_dac_step <= offset_dac_step(2'b00);
      ch2_offset_dac_step <= offset_dac_step(2'b00);
    end else begin
      ch1_range_quarter_pf <= input_range_qpf(ch1_range_sel);
      ch2_range_quarter_pf <= input_range_qpf(ch2_range_sel);
      ch1_offset_dac_step <= offset_dac_step(ch1_range_sel);
      ch2_offset_dac_step <= offset_dac_step(ch2_range_sel);
    end
  end

  // =====================================================================
  // per-channel tracking
  att_cmp_mode_e mode;
  logic window_mode;

  assign mode = att_cmp_mode_e'(comparator_mode_sel);
  assign window_mode = comparator_mode_sel[1];

  logic [7:0] timeout_cfg [2];
  logic [7:0] setup_cfg [2];
  logic [7:0] sens_raw [2];
  logic [DATA_W-1:0] fixed_thr [2];
  logic [DATA_W-1:0] avg [2];
  logic [DATA_W:0] upper [2];
  logic [DATA_W-1:0] lower [2];
  logic detect [2];

  assign timeout_cfg[0] = ch1_timeout_cfg;
  assign timeout_cfg[1] = ch2_timeout_cfg;
  assign setup_cfg[0] = ch1_threshold_setup;
  assign setup_cfg[1] = ch2_threshold_setup;
  assign sens_raw[0] = ch1_sensitivity;
  assign sens_raw[1] = ch2_sensitivity;
  assign fixed_thr[0] = ch1_fixed_threshold;
  assign fixed_thr[1] = ch2_fixed_threshold;

  for (genvar ch = 0; ch < 2; ch++) begin : g_ch
    logic strobe;
    logic [DATA_W-1:0] sens;
    logic [DATA_W-1:0] hys;
    logic above;
    logic below;
    logic above_hold;
    logic below_hold;
    logic hyst_on;
    logic approach;
    logic recede;
    logic force_load;
    logic next_detect;
    logic det;

    assign strobe = conv_valid && (conv_channel == ch[0]);
    assign sens = {{(DATA_W-8-ATT_SENS_SHIFT){1'b0}}, sens_raw[ch], {ATT_SENS_SHIFT{1'b0}}};
    assign hys = sens >> ATT_HYST_SHIFT;

    always_comb begin
      upper[ch] = {1'b0, avg[ch]} + {1'b0, sens};
      lower[ch] = sub_floor(avg[ch], sens);
      hyst_on = setup_cfg[ch][ATT_HYST_BIT] && !threshold_fixed;
      if (threshold_fixed) begin
        above = conv_data > fixed_thr[ch];
        below = conv_data < fixed_thr[ch];
        above_hold = above;
        below_hold = below;
      end else begin
        above = {1'b0, conv_data} > upper[ch];
        below = conv_data < lower[ch];
        // held output releases only a quarter sensitivity inside the band
        above_hold = {1'b0, conv_data} > (upper[ch] - {1'b0, hys});
        below_hold = {1'b0, conv_data} < ({1'b0, lower[ch]} + {1'b0, hys});
      end
      case (mode)
        ATT_MODE_NEGATIVE: begin
          approach = below;
          recede = above;
          next_detect = below || (hyst_on && det && below_hold);
        end
        ATT_MODE_POSITIVE: begin
          approach = above;
          recede = below;
          next_detect = above || (hyst_on && det && above_hold);
        end
        ATT_MODE_IN_WINDOW: begin
          approach = above || below;
          recede = 1'b0;
          next_detect = !above && !below && conv_data != lower[ch] &&
            {1'b0, conv_data} != upper[ch];
        end
        default: begin
          approach = above || below;
          recede = 1'b0;
          next_detect = above || below || (hyst_on && det && (above_hold || below_hold));
        end
      endcase
    end

    att_timeout_ctr u_timeout (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .conv_strobe(strobe),
      .timeout_enable(timeout_cfg[ch] != 8'h00),
      .side_approach(approach),
      .side_recede(recede && !window_mode),
      .approach_limit_exp(timeout_cfg[ch][ATT_APR_MSB:ATT_APR_LSB]),
      .recede_limit_exp(timeout_cfg[ch][ATT_REC_MSB:ATT_REC_LSB]),
      .force_load(force_load)
    );

    att_average u_average (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .conv_strobe(strobe),
      .force_load(force_load),
      .conv_data(conv_data),
      .average_settle_exp(setup_cfg[ch][ATT_SETTLE_MSB:ATT_SETTLE_LSB]),
      .average(avg[ch])
    );

    always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
        det <= 1'b0;
      end else if (strobe) begin
        det <= next_detect;
      end
    end

    assign detect[ch] = det;
  end

  // =====================================================================
  // outputs
  assign ch1_average = avg[0];
  assign ch2_average = avg[1];
  assign ch1_upper_threshold = upper[0];
  assign ch2_upper_threshold = upper[1];
  assign ch1_lower_threshold = lower[0];
  assign ch2_lower_threshold = lower[1];
  assign ch1_detect = detect[0];
  assign ch2_detect = detect[1];

endmodule : att_tracker
`default_nettype wire

// >>> verif/att_tracker_properties.sv
// checker: port-level properties of the adaptive threshold tracker
`default_nettype none
module att_tracker_properties
  import att_pkg::*;
#(
  parameter int DATA_W = ATT_DATA_W
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_wr_data,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_rd_data,
  input wire logic conv_valid,
  input wire logic conv_channel,
  input wire logic [7:0] ch1_sensitivity,
  input wire logic [DATA_W-1:0] ch1_average,
  input wire logic [DATA_W-1:0] ch2_average,
  input wire logic [DATA_W:0] ch1_upper_threshold,
  input wire logic [DATA_W-1:0] ch1_lower_threshold,
  input wire logic ch1_detect,
  input wire logic [4:0] ch1_range_quarter_pf,
  input wire logic [3:0] ch2_offset_dac_step
);
  // =====================================================================
  // helpers
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  logic [DATA_W-1:0] band1;
  assign band1 = DATA_W'({ch1_sensitivity, 4'h0});

  function automatic logic [4:0] range_q(input logic [1:0] r);
    return (r == 2'b00) ? 5'h08 : (r == 2'b01) ? 5'h02 : (r == 2'b10) ? 5'h04 : 5'h10;
  endfunction : range_q

  sequence s_ch1_setup_wr;
    reg_wr_en && reg_addr == ATT_OFS_CH1_SETUP;
  endsequence
  sequence s_ch2_setup_wr;
    reg_wr_en && reg_addr == ATT_OFS_CH2_SETUP;
  endsequence

  // =====================================================================
  // properties
  a_upper_thr_sum: assert property (ch1_upper_threshold == {1'b0, ch1_average} + {1'b0, band1})
    else $error("upper threshold is not average plus sensitivity");
  a_lower_thr_clamp: assert property (ch1_lower_threshold ==
    ((ch1_average > band1) ? ch1_average - band1 : '0))
    else $error("lower threshold is not average minus sensitivity");
  a_range_sel_decode: assert property (s_ch1_setup_wr |-> ##2
    ch1_range_quarter_pf == range_q($past(reg_wr_data[7:6], 2)))
    else $error("input range does not follow range bits");
  a_dac_step_decode: assert property (s_ch2_setup_wr |-> ##2
    ch2_offset_dac_step == 4'(range_q($past(reg_wr_data[7:6], 2)) >> 1))
    else $error("offset step does not follow range bits");
  a_unmapped_read_zero: assert property (reg_rd_en && reg_addr == 8'h0F |=> reg_rd_data == 8'h00)
    else $error("unmapped read returned nonzero");
  a_read_data_stands: assert property (!reg_rd_en |=> $stable(reg_rd_data))
    else $error("read data changed without a read");
  a_ch1_avg_conv: assert property ($changed(ch1_average) |-> $past(conv_valid && !conv_channel))
    else $error("channel one average moved without its conversion");
  a_ch2_avg_conv: assert property ($changed(ch2_average) |-> $past(conv_valid && conv_channel))
    else $error("channel two average moved without its conversion");
  a_detect_on_conv: assert property ($changed(ch1_detect) |-> $past(conv_valid && !conv_channel))
    else $error("channel one detect moved without its conversion");
endmodule : att_tracker_properties

bind att_tracker att_tracker_properties #(.DATA_W(DATA_W)) u_att_tracker_properties (
  .clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
  .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data),
  .conv_valid(conv_valid), .conv_channel(conv_channel), .ch1_sensitivity(ch1_sensitivity),
  .ch1_average(ch1_average), .ch2_average(ch2_average),
  .ch1_upper_threshold(ch1_upper_threshold), .ch1_lower_threshold(ch1_lower_threshold),
  .ch1_detect(ch1_detect), .ch1_range_quarter_pf(ch1_range_quarter_pf),
  .ch2_offset_dac_step(ch2_offset_dac_step));
`default_nettype wire

// >>> verif/att_tracker_tb.sv
// testbench: register and tracking checks of the adaptive threshold tracker
`default_nettype none
module att_tracker_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import att_pkg::*;

  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr_en = 1'b0;
  logic [7:0] reg_wr_data = 8'h00;
  logic reg_rd_en = 1'b0;
  logic [7:0] reg_rd_data;
  logic [1:0] comparator_mode_sel = 2'b01;
  logic conv_valid = 1'b0;
  logic conv_channel = 1'b0;
  logic [15:0] conv_data = 16'h0000;
  logic [15:0] ch1_average, ch2_average, ch1_lower_threshold, ch2_lower_threshold;
  logic [16:0] ch1_upper_threshold, ch2_upper_threshold;
  logic ch1_detect, ch2_detect;
  logic [4:0] ch1_range_quarter_pf, ch2_range_quarter_pf;
  logic [3:0] ch1_offset_dac_step, ch2_offset_dac_step;
  logic [4:0] rng [4] = '{5'h08, 5'h02, 5'h04, 5'h10};
  int failures = 0;
  int n_checks = 0;

  always #12.5 clk_sys = ~clk_sys;

  att_tracker u_att_tracker (
    .clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data),
    .threshold_fixed(1'b0), .comparator_mode_sel(comparator_mode_sel),
    .ch1_sensitivity(8'h10), .ch2_sensitivity(8'h10),
    .ch1_fixed_threshold(16'h0000), .ch2_fixed_threshold(16'h0000),
    .conv_valid(conv_valid), .conv_channel(conv_channel), .conv_data(conv_data),
    .ch1_average(ch1_average), .ch2_average(ch2_average),
    .ch1_upper_threshold(ch1_upper_threshold), .ch2_upper_threshold(ch2_upper_threshold),
    .ch1_lower_threshold(ch1_lower_threshold), .ch2_lower_threshold(ch2_lower_threshold),
    .ch1_detect(ch1_detect), .ch2_detect(ch2_detect),
    .ch1_range_quarter_pf(ch1_range_quarter_pf), .ch2_range_quarter_pf(ch2_range_quarter_pf),
    .ch1_offset_dac_step(ch1_offset_dac_step), .ch2_offset_dac_step(ch2_offset_dac_step));

  // =====================================================================
  // tasks, all entered and left at a falling edge, except wrap_up from the time limit, entered at a rising edge
  task automatic wrap_up();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input bit same);
    n_checks++;
    if (((got === exp) !== same) || $isunknown(got)) begin
      failures++;
      $display("unexpected at %0t: got %h ref %h match %0d", $time, got, exp, same);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wr_data = d;
    reg_wr_en = 1'b1;
    @(negedge clk_sys);
    reg_wr_en = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(negedge clk_sys);
    reg_rd_en = 1'b0;
    chk({8'h00, reg_rd_data}, {8'h00, e}, 1'b1);
  endtask : rd

  task automatic conv(input logic ch, input logic [15:0] d);
    conv_channel = ch;
    conv_data = d;
    conv_valid = 1'b1;
    @(negedge clk_sys);
    conv_valid = 1'b0;
  endtask : conv

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask : done

  // =====================================================================
  // sequence of tests
  initial begin
    repeat (20) @(negedge clk_sys);
    reset_n = 1'b1;
    rd(ATT_OFS_CH1_TIMEOUT, ATT_TIMEOUT_RESET);
    rd(ATT_OFS_CH2_TIMEOUT, ATT_TIMEOUT_RESET);
    rd(ATT_OFS_CH1_SETUP, ATT_SETUP_RESET);
    rd(ATT_OFS_CH2_SETUP, ATT_SETUP_RESET);
    chk(16'(ch1_range_quarter_pf), 16'h0008, 1'b1);
    chk(16'(ch1_offset_dac_step), 16'h0004, 1'b1);
    wr(8'h0F, 8'hFF);
    rd(8'h0F, 8'h00);
    done("reset values");
    for (int i = 0; i < 4; i++) begin
      wr(ATT_OFS_CH1_SETUP, 8'((i << 6) | 15));
      wr(ATT_OFS_CH2_SETUP, 8'(i << 6));
      rd(ATT_OFS_CH1_SETUP, 8'((i << 6) | 15));
      chk(16'(ch1_range_quarter_pf), 16'(rng[i]), 1'b1);
      chk(16'(ch1_offset_dac_step), 16'(rng[i] >> 1), 1'b1);
    end
    done("range table");
    // slow settling keeps the average far from the data, so only a forced load can match
    wr(ATT_OFS_CH1_TIMEOUT, 8'h21);
    for (int i = 1; i <= 4; i++) begin
      conv(1'b0, 16'h8000);
      chk(ch1_average, 16'h8000, i == 4);
      chk(16'(ch1_detect), 16'h0001, 1'b1);
    end
    for (int i = 1; i <= 2; i++) begin
      conv(1'b0, 16'h1000);
      chk(ch1_average, 16'h1000, i == 2);
    end
    done("approach and recede");
    comparator_mode_sel = 2'b10;
    wr(ATT_OFS_CH1_TIMEOUT, 8'h30);
    for (int i = 1; i <= 8; i++) begin
      conv(1'b0, 16'h0100);
      chk(ch1_average, 16'h0100, i == 8);
    end
    done("window mode");
    comparator_mode_sel = 2'b01;
    wr(ATT_OFS_CH1_TIMEOUT, 8'h00);
    repeat (20) conv(1'b0, 16'hF000);
    chk(ch1_average, 16'hF000, 1'b0);
    done("timeouts off");
    wr(ATT_OFS_CH2_TIMEOUT, 8'h00);
    conv(1'b1, 16'h8000);
    chk(ch2_average, 16'h4000, 1'b1);
    conv(1'b1, 16'h8000);
    chk(ch2_average, 16'h6000, 1'b1);
    wr(ATT_OFS_CH2_SETUP, 8'h01);
    conv(1'b1, 16'h8000);
    chk(ch2_average, 16'h6800, 1'b1);
    chk(ch2_upper_threshold[15:0], 16'h6900, 1'b1);
    chk(ch2_lower_threshold, 16'h6700, 1'b1);
    chk(16'(ch2_detect), 16'h0001, 1'b1);
    chk(16'(ch2_range_quarter_pf), 16'h0008, 1'b1);
    done("settling");
    wrap_up();
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    $display("unexpected at %0t: run did not finish", $time);
    wrap_up();
  end
endmodule : att_tracker_tb
`default_nettype wire
